// ===== sim/ses_properties.sv
// Concurrent checks on the serial link between master and device
`timescale 1ns/100ps
module ses_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Helper: sck rises inside the current frame, modulo one byte
    logic [2:0] rise_cnt;
    logic       sck_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cnt <= 3'h0;
            sck_q    <= 1'b0;
        end else begin
            sck_q <= sck;
            if (cs_n) begin
                rise_cnt <= 3'h0;
            end else if (sck && !sck_q) begin
                rise_cnt <= rise_cnt + 3'h1;
            end
        end
    end

    // ==========================================================
    // Sequences
    // Five cycles cover the two-flop synchroniser plus the output flop
    sequence s_desel;
        cs_n [*5];
    endsequence
    sequence s_paused;
        (!cs_n && !hold_n) [*5];
    endsequence

    AST_DESEL_RELEASES: assert property (s_desel |-> miso_oe_n)
        else $error("serial output driven while deselected");
    AST_HOLD_RELEASES: assert property (s_paused |-> miso_oe_n)
        else $error("serial output driven during hold");
    AST_MISO_AFTER_FALL: assert property (
        !miso_oe_n && !$past(miso_oe_n) && $changed(miso_o) |-> !sck)
        else $error("serial output changed outside clock low phase");
    AST_MOSI_STABLE: assert property (
        !cs_n && sck && $past(sck) |-> $stable(mosi))
        else $error("serial input moved while clock high");
    AST_SCK_HALF: assert property ($rose(sck) |-> sck [*4])
        else $error("clock high phase shorter than half period");
    AST_HOLD_CLK_LOW: assert property (
        !cs_n && $changed(hold_n) |-> !sck)
        else $error("hold moved while clock high");
    AST_WP_STABLE: assert property (!cs_n && !$past(cs_n) |-> $stable(wp_n))
        else $error("write protect moved inside a frame");
    AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> rise_cnt == 3'h0)
        else $error("frame ended on a partial byte");
endmodule : ses_properties

// ===== sim/tb_top.sv
// Testbench joining master and device across the serial link
`timescale 1ns/100ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, tx_data, got_rx;
    logic [31:0] pwdata, prdata, rd;
    logic        err, tx_en, cycle_busy, status_wr, nv_lock, got_first;
    logic [2:0]  status_wr_data;
    logic [1:0]  nv_protect;
    logic        selected, holding, rx_strobe, rx_first, frame_end, frame_aligned;
    logic        tx_req, power_active, protect_range_hi, protect_range_lo;
    logic        status_lock_enable;
    logic [7:0]  rx_byte;
    int          num_errors, checks_done;
    int          num_req = 0, num_end = 0;

    ses_link_if link ();
    ses_master #(.HALF_CYC(ses_pkg::HALF_CYC)) i_ses_master (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    ses_device i_ses_device (.pclk(pclk), .presetn(presetn), .link(link),
        .tx_en(tx_en), .tx_data(tx_data), .cycle_busy(cycle_busy),
        .status_wr(status_wr), .status_wr_data(status_wr_data),
        .nv_protect(nv_protect), .nv_lock(nv_lock), .selected(selected),
        .holding(holding), .rx_byte(rx_byte), .rx_strobe(rx_strobe),
        .rx_first(rx_first), .frame_end(frame_end), .frame_aligned(frame_aligned),
        .tx_req(tx_req), .power_active(power_active),
        .protect_range_hi(protect_range_hi), .protect_range_lo(protect_range_lo),
        .status_lock_enable(status_lock_enable));
    ses_properties i_ses_properties (.pclk(pclk), .presetn(presetn), .sck(link.sck),
        .cs_n(link.cs_n), .mosi(link.mosi), .hold_n(link.hold_n), .wp_n(link.wp_n),
        .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Keeps the last byte the device delivered to its core
    always @(posedge pclk) begin
        if (rx_strobe === 1'b1) begin
            got_rx    <= rx_byte;
            got_first <= rx_first;
        end
        if (tx_req === 1'b1) num_req <= num_req + 1;
        if (frame_end === 1'b1) num_end <= num_end + 1;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Polls status until the shifter is idle; a bounded count guards a hang
    task automatic wait_idle;
        int n = 0;
        do begin
            apb(1'b0, ses_pkg::STAT_OFF, 32'h0);
            n++;
        end while (rd[ses_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 100);
        if (rd[ses_pkg::STAT_BUSY_BIT] !== 1'b0) num_errors++;
    endtask : wait_idle

    task automatic send(input logic [7:0] b);
        apb(1'b1, ses_pkg::TX_OFF, {24'h0, b});
        wait_idle();
        apb(1'b0, ses_pkg::RX_OFF, 32'h0);
    endtask : send

    task automatic prot_write(input logic [2:0] v);
        repeat (5) @(posedge pclk);
        status_wr      <= 1'b1;
        status_wr_data <= v;
        @(posedge pclk);
        status_wr <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : prot_write

    task automatic give_verdict;
        $display("errors %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (30000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; tx_en = 1'b0; tx_data = 8'h00;
        cycle_busy = 1'b0; status_wr = 1'b0; status_wr_data = 3'h0;
        nv_protect = 2'h2; nv_lock = 1'b1; num_errors = 0; checks_done = 0;
        repeat (4) @(posedge pclk);
        chk(32'(selected), 32'h0);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'({status_lock_enable, protect_range_hi, protect_range_lo}), 32'h6);
        chk(32'(power_active), 32'h0);
        apb(1'b0, ses_pkg::CTRL_OFF, 32'h0);
        chk(rd, 32'h4);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Read-type frame: core answers the first byte with a reply
        tx_data <= 8'h3c;
        tx_en   <= 1'b1;
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h5);
        repeat (5) @(posedge pclk);
        chk(32'(selected), 32'h1);
        chk(32'(power_active), 32'h1);
        send(8'ha5);
        chk(32'(got_rx), 32'ha5);
        chk(32'(got_first), 32'h1);
        send(8'h00);
        chk(rd, 32'h3c);
        chk(32'(got_first), 32'h0);
        tx_en      <= 1'b0;
        cycle_busy <= 1'b1;
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h4);
        repeat (6) @(posedge pclk);
        chk(32'(selected), 32'h0);
        chk(32'(link.miso_oe_n), 32'h1);
        chk(32'(frame_aligned), 32'h1);
        chk(num_end, 32'h1);
        chk(num_req, 32'h2);
        chk(32'(power_active), 32'h1);
        cycle_busy <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(power_active), 32'h0);
        // Clock idle high
        apb(1'b1, ses_pkg::CTRL_OFF, 32'hc);
        apb(1'b1, ses_pkg::CTRL_OFF, 32'hd);
        send(8'h5a);
        chk(32'(got_rx), 32'h5a);
        chk(32'(got_first), 32'h1);
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h4);
        // Pause in mid-byte, then resume
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h5);
        apb(1'b1, ses_pkg::TX_OFF, 32'hc3);
        repeat (20) @(posedge pclk);
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h7);
        repeat (12) @(posedge pclk);
        chk(32'(holding), 32'h1);
        chk(32'(link.miso_oe_n), 32'h1);
        apb(1'b0, ses_pkg::STAT_OFF, 32'h0);
        chk(rd, 32'h3);
        repeat (40) @(posedge pclk);
        chk(32'(got_rx), 32'h5a);
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h5);
        wait_idle();
        chk(32'(got_rx), 32'hc3);
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h4);
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h6);
        repeat (8) @(posedge pclk);
        chk(32'(holding), 32'h0);
        // Protect bits frozen while write protect is low
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h0);
        prot_write(3'h3);
        chk(32'({status_lock_enable, protect_range_hi, protect_range_lo}), 32'h6);
        apb(1'b1, ses_pkg::CTRL_OFF, 32'h4);
        prot_write(3'h3);
        chk(32'({status_lock_enable, protect_range_hi, protect_range_lo}), 32'h3);
        give_verdict();
    end
endmodule : tb_top

// ===== src/ses_device.sv
// EEPROM serial front end: select, shifting, hold, protect bits, power mode
`timescale 1ns/100ps
module ses_device (
    input  wire logic       pclk,
    input  wire logic       presetn,
    ses_link_if.dev         link,
    input  wire logic       tx_en,
    input  wire logic [7:0] tx_data,
    input  wire logic       cycle_busy,
    input  wire logic       status_wr,
    input  wire logic [2:0] status_wr_data,
    input  wire logic [1:0] nv_protect,
    input  wire logic       nv_lock,
    output logic            selected,
    output logic            holding,
    output logic      [7:0] rx_byte,
    output logic            rx_strobe,
    output logic            rx_first,
    output logic            frame_end,
    output logic            frame_aligned,
    output logic            tx_req,
    output logic            power_active,
    output logic            protect_range_hi,
    output logic            protect_range_lo,
    output logic            status_lock_enable
);

    // ==========================================================
    // State
    typedef struct packed {
        logic                           armed;
        logic                           sel;
        logic                           holding;
        logic                           sck_prev;
        logic [ses_pkg::CNT_W-1:0]      bitcnt;
        logic [ses_pkg::BYTE_W-1:0]     rx_shift;
        logic [ses_pkg::BYTE_W-1:0]     rx_byte;
        logic                           rx_strobe;
        logic                           rx_first;
        logic                           first_pending;
        logic                           byte_seen;
        logic                           frame_end;
        logic                           frame_aligned;
        logic [ses_pkg::BYTE_W-1:0]     tx_shift;
        logic                           tx_req;
        logic                           miso;
        logic                           miso_oe_n;
        logic                           power_active;
        logic                           nv_loaded;
        logic                           prot_hi;
        logic                           prot_lo;
        logic                           lock;
    } ses_dev_state_t;

    ses_dev_state_t r_reg;
    ses_dev_state_t r_next;

    // ==========================================================
    // Pin synchronisation
    logic [4:0] pins_s;
    logic       sck_s;
    logic       cs_s;
    logic       mosi_s;
    logic       hold_s;
    logic       wp_s;
    logic       rise;
    logic       fall;

    ses_sync #(
        .W (5)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link.sck, link.cs_n, link.mosi, link.hold_n, link.wp_n}),
        .q       (pins_s)
    );

    assign {sck_s, cs_s, mosi_s, hold_s, wp_s} = pins_s;
    assign rise = sck_s & ~r_reg.sck_prev;
    assign fall = ~sck_s & r_reg.sck_prev;

    // ==========================================================
    // Next state
    always_comb begin
        r_next           = r_reg;
        r_next.rx_strobe = 1'b0;
        r_next.tx_req    = 1'b0;
        r_next.frame_end = 1'b0;
        r_next.sck_prev  = sck_s;

        // Stored range and lock bits are taken once after reset release
        if (!r_reg.nv_loaded) begin
            r_next.nv_loaded = 1'b1;                                       // [RL17]
            r_next.prot_hi   = nv_protect[1];                              // [RL17]
            r_next.prot_lo   = nv_protect[0];                              // [RL17]
            r_next.lock      = nv_lock;                                    // [RL17]
        end else if (status_wr && wp_s) begin
            // Write protect low blocks every status update of these bits
            r_next.lock    = status_wr_data[2];                            // [RL10]
            r_next.prot_hi = status_wr_data[1];                            // [RL10]
            r_next.prot_lo = status_wr_data[0];                            // [RL10]
        end

        // Arming needs select seen high, so a falling edge must follow
        if (cs_s) begin
            r_next.armed = 1'b1;                                           // [RL6]
        end

        if (cs_s) begin
            // Deselect: drop any partial byte and release the output
            if (r_reg.sel) begin
                r_next.frame_end     = 1'b1;
                r_next.frame_aligned = (r_reg.bitcnt == '0) && r_reg.byte_seen;
            end
            r_next.sel           = 1'b0;                                   // [RL3]
            r_next.holding       = 1'b0;                                   // [RL19]
            r_next.bitcnt        = '0;                                     // [RL21]
            r_next.rx_shift      = ses_pkg::BYTE_RST;                      // [RL21]
            r_next.byte_seen     = 1'b0;
            r_next.first_pending = 1'b1;
            r_next.miso_oe_n     = 1'b1;                                   // [RL3]
        end else if (r_reg.armed) begin
            r_next.sel = 1'b1;                                             // [RL6]
            // Hold changes are only honoured with the clock low
            if (!r_reg.holding && !hold_s && !sck_s) begin
                r_next.holding = 1'b1;                                     // [RL9] [RL18]
            end else if (r_reg.holding && hold_s && !sck_s) begin
                r_next.holding = 1'b0;                                     // [RL20]
            end

            // Edges are ignored in hold; counters stay put to resume later
            if (!r_reg.holding && !r_next.holding && rise) begin           // [RL7] [RL8]
                r_next.rx_shift = {r_reg.rx_shift[6:0], mosi_s};           // [RL2] [RL12]
                r_next.bitcnt   = r_reg.bitcnt + 1'b1;
                if (r_reg.bitcnt == 3'h7) begin
                    r_next.rx_byte       = {r_reg.rx_shift[6:0], mosi_s};  // [RL12]
                    r_next.rx_strobe     = 1'b1;
                    r_next.rx_first      = r_reg.first_pending;
                    r_next.first_pending = 1'b0;
                    r_next.byte_seen     = 1'b1;
                end
            end

            // Falling edges drive the output only once a read is decoded
            if (!r_reg.holding && !r_next.holding && fall && tx_en) begin  // [RL14]
                if (r_reg.bitcnt == '0) begin
                    r_next.miso     = tx_data[7];                          // [RL1] [RL13]
                    r_next.tx_shift = {tx_data[6:0], 1'b0};                // [RL13]
                    r_next.tx_req   = 1'b1;
                end else begin
                    r_next.miso     = r_reg.tx_shift[7];                   // [RL1]
                    r_next.tx_shift = {r_reg.tx_shift[6:0], 1'b0};
                end
            end

            r_next.miso_oe_n = r_next.holding;                             // [RL8]
        end

        // A running write cycle keeps the part out of standby
        r_next.power_active = r_next.sel | cycle_busy;                     // [RL4] [RL5]
    end

    // ==========================================================
    // State register; reset doubles as power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg               <= '0;                                     // [RL15] [RL16]
            r_reg.miso_oe_n     <= 1'b1;                                   // [RL16]
            r_reg.first_pending <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs
    assign link.miso_o         = r_reg.miso;
    assign link.miso_oe_n      = r_reg.miso_oe_n;
    assign selected            = r_reg.sel;
    assign holding             = r_reg.holding;
    assign rx_byte             = r_reg.rx_byte;
    assign rx_strobe           = r_reg.rx_strobe;
    assign rx_first            = r_reg.rx_first;
    assign frame_end           = r_reg.frame_end;
    assign frame_aligned       = r_reg.frame_aligned;
    assign tx_req              = r_reg.tx_req;
    assign power_active        = r_reg.power_active;
    assign protect_range_hi    = r_reg.prot_hi;
    assign protect_range_lo    = r_reg.prot_lo;
    assign status_lock_enable  = r_reg.lock;

endmodule : ses_device

// ===== src/ses_link_if.sv
// Serial link between the bus master and the EEPROM front end
`timescale 1ns/100ps
interface ses_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic miso_o;
    logic miso_oe_n;
    logic miso;

    // Released line reads high, as with a pull-up
    assign miso = miso_oe_n ? 1'b1 : miso_o;

    modport dev (
        input  sck,
        input  cs_n,
        input  mosi,
        input  hold_n,
        input  wp_n,
        output miso_o,
        output miso_oe_n
    );

    modport host (
        output sck,
        output cs_n,
        output mosi,
        output hold_n,
        output wp_n,
        input  miso
    );
endinterface : ses_link_if

// ===== src/ses_master.sv
// SPI bus master with an APB register front
`timescale 1ns/100ps
module ses_master #(
    parameter int unsigned HALF_CYC = ses_pkg::HALF_CYC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ses_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    ses_link_if.host                        link
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [3:0]  ctrl;
        logic        busy;
        logic [7:0]  phase;
        logic [2:0]  bitcnt;
        logic [7:0]  tx_shift;
        logic [7:0]  rx_shift;
        logic [7:0]  rx_data;
        logic        sck;
        logic        mosi;
        logic        cs_n;
        logic        hold_n;
        logic        wp_n;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ses_mst_state_t;

    ses_mst_state_t r_reg;
    ses_mst_state_t r_next;
    logic           miso_s;
    logic           acc;
    logic           done;

    ses_sync #(
        .W (1)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (link.miso),
        .q       (miso_s)
    );

    assign acc  = psel & penable & ~r_reg.pready;
    assign done = psel & penable & r_reg.pready;

    always_comb begin
        r_next         = r_reg;
        r_next.pready  = acc;
        r_next.pslverr = 1'b0;
        r_next.prdata  = '0;

        // ======================================================
        // Register access: answer one cycle into the access phase
        if (acc) begin
            if (paddr == ses_pkg::CTRL_OFF) begin
                r_next.prdata = {28'h0000000, r_reg.ctrl};
            end else if (paddr == ses_pkg::TX_OFF) begin
                r_next.prdata = '0;
            end else if (paddr == ses_pkg::RX_OFF) begin
                r_next.prdata = {24'h000000, r_reg.rx_data};
            end else if (paddr == ses_pkg::STAT_OFF) begin
                r_next.prdata = {30'h0, ~r_reg.hold_n, r_reg.busy};
            end else begin
                r_next.pslverr = 1'b1;
            end
        end
        if (done && pwrite) begin
            if (paddr == ses_pkg::CTRL_OFF) begin
                r_next.ctrl = pwdata[3:0];
            end else if (paddr == ses_pkg::TX_OFF && !r_reg.busy && !r_reg.cs_n
                         && r_reg.hold_n) begin
                // A byte write is refused while busy, deselected or holding
                r_next.busy     = 1'b1;
                r_next.phase    = '0;
                r_next.bitcnt   = '0;
                r_next.sck      = 1'b0;
                r_next.mosi     = pwdata[7];                           // [RL12]
                r_next.tx_shift = {pwdata[6:0], 1'b0};
            end
        end

        // ======================================================
        // Pins that only change between bytes
        if (!r_reg.busy) begin
            r_next.cs_n = ~r_reg.ctrl[ses_pkg::CTRL_SEL_BIT];
            if (r_reg.cs_n) begin
                r_next.wp_n = r_reg.ctrl[ses_pkg::CTRL_WP_BIT];        // [RL11]
                r_next.sck  = r_reg.ctrl[ses_pkg::CTRL_CPOL_BIT];      // [RL14]
            end
        end
        // Hold only toggles with the clock low and the part selected
        if (r_reg.cs_n) begin
            r_next.hold_n = 1'b1;                                      // [RL9]
        end else if (!r_reg.sck && !(r_reg.hold_n && r_reg.busy
                     && r_reg.phase == 8'(HALF_CYC - 1))) begin
            // Hold may not fall on the edge that raises the clock
            r_next.hold_n = ~r_reg.ctrl[ses_pkg::CTRL_HOLD_BIT];       // [RL18]
        end

        // ======================================================
        // Shift engine; frozen in hold so the byte resumes in place
        if (r_reg.busy && r_reg.hold_n) begin
            if (r_reg.phase != 8'(HALF_CYC - 1)) begin
                r_next.phase = r_reg.phase + 8'h01;
            end else begin
                r_next.phase = '0;
                if (!r_reg.sck) begin
                    r_next.sck = 1'b1;
                end else begin
                    // Late sample allows for the device's pin latency
                    r_next.rx_shift = {r_reg.rx_shift[6:0], miso_s};
                    if (r_reg.bitcnt == 3'h7) begin
                        r_next.busy    = 1'b0;
                        r_next.rx_data = {r_reg.rx_shift[6:0], miso_s};
                        r_next.sck     = r_reg.ctrl[ses_pkg::CTRL_CPOL_BIT];
                    end else begin
                        r_next.sck      = 1'b0;
                        r_next.bitcnt   = r_reg.bitcnt + 3'h1;
                        r_next.mosi     = r_reg.tx_shift[7];
                        r_next.tx_shift = {r_reg.tx_shift[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // ==========================================================
    // Select starts high so the device sees a falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg        <= '0;
            r_reg.ctrl   <= ses_pkg::CTRL_RST;
            r_reg.cs_n   <= 1'b1;                                      // [RL6]
            r_reg.hold_n <= 1'b1;
            r_reg.wp_n   <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata      = r_reg.prdata;
    assign pready      = r_reg.pready;
    assign pslverr     = r_reg.pslverr;
    assign link.sck    = r_reg.sck;
    assign link.mosi   = r_reg.mosi;
    assign link.cs_n   = r_reg.cs_n;
    assign link.hold_n = r_reg.hold_n;
    assign link.wp_n   = r_reg.wp_n;

endmodule : ses_master

// ===== src/ses_pkg.sv
// Shared constants for the serial EEPROM front end and its bus master
// Summary of operation
// RL1: Output bit changes after serial clock falls
// RL2: Input bits captured on serial clock rise
// RL3: Deselected: serial output stays released
// RL4: Deselected standby, unless write cycle running
// RL5: Select low means active power mode
// RL6: Select needs a falling edge after power-up
// RL7: Hold pauses transfer, sequence resumes later
// RL8: Hold releases output, ignores data, clock
// RL9: Hold only entered while device selected
// RL10: Write protect freezes the protect-range bits
// RL11: Master keeps write protect stable during frame
// RL12: Input shifted MSB first from first rise
// RL13: Output MSB first from next fall
// RL14: Clock modes 0 and 3 both supported
// RL15: Nothing decoded while power-on reset active
// RL16: Reset: deselected, standby, latch, busy cleared
// RL17: Reset keeps lock and range bits stored
// RL18: Hold starts only with clock low
// RL19: Deselect in hold resets protocol only
// RL20: Hold ends with clock low, resumes
// RL21: Deselect drops partial byte, counter restarts
package ses_pkg;

    // ==========================================================
    // Link and timing
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned CNT_W        = 3;
    localparam int unsigned SYNC_STAGES  = 2;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SCK_PERIOD_NS = 800;
    localparam int unsigned HALF_CYC     = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // ==========================================================
    // Master register map (byte addresses)
    localparam int unsigned ADDR_W   = 8;
    localparam logic [7:0] CTRL_OFF  = 8'h00;
    localparam logic [7:0] TX_OFF    = 8'h04;
    localparam logic [7:0] RX_OFF    = 8'h08;
    localparam logic [7:0] STAT_OFF  = 8'h0c;

    // Control field positions
    localparam int unsigned CTRL_SEL_BIT  = 0;
    localparam int unsigned CTRL_HOLD_BIT = 1;
    localparam int unsigned CTRL_WP_BIT   = 2;
    localparam int unsigned CTRL_CPOL_BIT = 3;

    // Status field positions
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_HOLD_BIT = 1;

    // Reset values
    localparam logic [3:0] CTRL_RST = 4'h4;
    localparam logic [7:0] BYTE_RST = 8'h00;

endpackage : ses_pkg

// ===== src/ses_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module ses_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : ses_sync
